// >>> rbpc_pkg.sv
// rbpc_pkg: constants, types and register map of the reset/boot/power block
package rbpc_pkg;

  // timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int HW_RST_MIN_NS   = 100;
  localparam int HW_RST_MIN_CYC  =
    (HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_STRETCH_CYC = 8;

  // register map
  localparam logic [3:0] ADDR_CTRL       = 4'h0;
  localparam logic [3:0] ADDR_STATUS     = 4'h1;
  localparam logic [3:0] ADDR_WDT_CTRL   = 4'h2;
  localparam logic [3:0] ADDR_WDT_RELOAD = 4'h3;

  // field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_DIV_LSB   = 2;
  localparam int STAT_CAUSE_LSB = 0;
  localparam int STAT_BOOT_LSB  = 4;
  localparam int STAT_RAM_BIT   = 6;
  localparam int STAT_JTAG_BIT  = 7;
  localparam int WDT_EN_BIT     = 0;
  localparam int WDT_SERV_BIT   = 1;

  // reset values
  localparam logic [2:0]  DIV_RST        = 3'h0;
  localparam logic [7:0]  WDT_RELOAD_RST = 8'hff;
  localparam logic [7:0]  WDT_LOW_FILL   = 8'hff;
  localparam logic [15:0] PC_START       = 16'h0000;

  typedef enum logic [1:0] {
    BOOT_USER      = 2'h0,
    BOOT_LOADER    = 2'h1,
    BOOT_DEBUG     = 2'h2,
    BOOT_JTAG_USER = 2'h3
  } rbpc_boot_t;

  typedef enum logic [1:0] {
    PM_RUN   = 2'h0,
    PM_IDLE  = 2'h1,
    PM_SLOW  = 2'h2,
    PM_PDOWN = 2'h3
  } rbpc_pm_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_RUN   = 3'h1,
    ST_SLOW  = 3'h3,
    ST_IDLE  = 3'h2,
    ST_PDOWN = 3'h6
  } rbpc_state_t;

  typedef struct packed {
    logic osc_en;
    logic pll_en;
    logic evr_on;
    logic cpu_clk_en;
    logic periph_clk_en;
  } rbpc_clk_t;

  typedef struct packed {
    logic wake;
    logic wdt;
    logic hw;
    logic por;
  } rbpc_cause_t;

  typedef struct packed {
    logic boot_mode_pin;
    logic tms;
    logic port_zero_bit_zero;
  } rbpc_strap_t;

  typedef struct packed {
    rbpc_boot_t  mode;
    logic        jtag_hot_attach;
    logic [15:0] pc_start;
  } rbpc_boot_info_t;

endpackage

// >>> rbpc_reset_sync.sv
// rbpc_reset_sync: synchroniser and width filter for the external reset pin
module rbpc_reset_sync (
  input  logic clk_sys_in,
  input  logic rst_in,
  input  logic ext_reset_n_in,
  output logic hw_reset_out
);
  import rbpc_pkg::*;

  logic       meta_reg, meta_next;
  logic       sync_reg, sync_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       hw_reg, hw_next;

  always_comb begin
    meta_next = ext_reset_n_in;
    sync_next = meta_reg;
    if (sync_reg) begin
      cnt_next = 3'h0;
    end else if (cnt_reg < 3'(HW_RST_MIN_CYC)) begin
      cnt_next = cnt_reg + 3'h1;
    end else begin
      cnt_next = cnt_reg;
    end
    // shorter glitches never reach the core
    hw_next = (cnt_next == 3'(HW_RST_MIN_CYC));
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      cnt_reg  <= 3'h0;
      hw_reg   <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      cnt_reg  <= cnt_next;
      hw_reg   <= hw_next;
    end
  end

  assign hw_reset_out = hw_reg;

  a_pin_low_seen: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (!ext_reset_n_in) [*4] |=> hw_reset_out)
    else $error("held reset pin not recognised");

  a_pin_high_free: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ext_reset_n_in [*3] |=> !hw_reset_out)
    else $error("reset not released after pin high");

endmodule

// >>> rbpc_clk_div.sv
// rbpc_clk_div: common clock-enable divider for slow-down mode
module rbpc_clk_div (
  input  logic       clk_sys_in,
  input  logic       rst_in,
  input  logic       enable_in,
  input  logic [2:0] factor_in,
  output logic       tick_out
);
  import rbpc_pkg::*;

  logic [2:0] cnt_reg, cnt_next;
  logic       tick_reg, tick_next;

  always_comb begin
    if (!enable_in || cnt_reg >= factor_in) begin
      cnt_next = 3'h0;
    end else begin
      cnt_next = cnt_reg + 3'h1;
    end
    // one tick every factor+1 cycles; full rate when disabled
    tick_next = !enable_in || (cnt_reg >= factor_in);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg  <= 3'h0;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

  a_div_spacing: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    enable_in && $past(enable_in) && tick_out && factor_in != 3'h0
    && $stable(factor_in) |=> enable_in && !tick_out || !enable_in)
    else $error("divider ticked twice in a row");

endmodule

// >>> rbpc_top.sv
// rbpc_top: reset recognition, boot selection and power-saving control
//////////////////////////////////////////////////////////////////////////////
// Operation
// - hardware reset honoured in normal operation and in power-down
// - watchdog expiry forces a full device reset
// - reset in power-down flagged as wake-up; ram kept, lost on power-on
// - wake-up reset switches the voltage regulator back on
// - after power-on or hardware reset sample the three boot straps
// - boot pin 1, tms 0: user mode, oscillator/pll on, start 0000
// - boot pin 0, tms 0: bootstrap loader mode, start 0000
// - 0,1,0 selects debug mode, refused when flash is protected
// - 1,1,0 selects user mode with jtag hot attach
// - idle stops only the cpu clock
// - slow-down divides cpu and peripheral clocks by one factor
// - power-down switches oscillator and pll off
//////////////////////////////////////////////////////////////////////////////
//
// Design decisions made here: the address map and the address-and-strobe port.
module rbpc_top (
  input  logic                      clk_sys_in,
  input  logic                      rst_in,
  input  logic                      ext_reset_n_in,
  input  rbpc_pkg::rbpc_strap_t     strap_in,
  input  logic                      flash_protected_in,
  input  logic                      wake_event_in,
  input  logic [3:0]                addr_in,
  input  logic [7:0]                wdata_in,
  input  logic                      wr_in,
  input  logic                      rd_in,
  output logic [7:0]                rdata_out,
  output logic                      sys_reset_out,
  output rbpc_pkg::rbpc_clk_t       clk_ctl_out,
  output rbpc_pkg::rbpc_boot_info_t boot_out,
  output rbpc_pkg::rbpc_cause_t     cause_out,
  output logic                      ram_valid_out
);
  import rbpc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // strap decode

  function automatic rbpc_boot_info_t decode_boot(input rbpc_strap_t s,
                                                  input logic prot);
    rbpc_boot_info_t b;
    b.pc_start        = PC_START;
    b.jtag_hot_attach = 1'b0;
    b.mode            = BOOT_USER;
    if (!s.tms) begin
      b.mode = s.boot_mode_pin ? BOOT_USER : BOOT_LOADER;
    end else if (!s.port_zero_bit_zero) begin
      if (s.boot_mode_pin) begin
        b.mode            = BOOT_JTAG_USER;
        b.jtag_hot_attach = 1'b1;
      end else if (!prot) begin
        b.mode = BOOT_DEBUG;
      end
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // submodules

  logic hw_level;
  logic div_tick;
  logic div_en;

  rbpc_reset_sync u_sync (
    .clk_sys_in     (clk_sys_in),
    .rst_in         (rst_in),
    .ext_reset_n_in (ext_reset_n_in),
    .hw_reset_out   (hw_level)
  );

  logic [2:0] div_reg, div_next;

  rbpc_clk_div u_div (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .enable_in  (div_en),
    .factor_in  (div_reg),
    .tick_out   (div_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // state

  rbpc_state_t     state_reg, state_next;
  logic [3:0]      stretch_reg, stretch_next;
  rbpc_cause_t     cause_reg, cause_next;
  logic            ram_reg, ram_next;
  rbpc_boot_info_t boot_reg, boot_next;
  rbpc_clk_t       clk_reg, clk_next;
  logic            sysrst_reg, sysrst_next;
  logic            wdt_en_reg, wdt_en_next;
  logic [7:0]      reload_reg, reload_next;
  logic [15:0]     wdt_cnt_reg, wdt_cnt_next;
  logic [7:0]      rdata_reg, rdata_next;
  logic            wdt_expire;
  logic            boot_sample;
  logic            ctrl_wr;
  rbpc_pm_t        pm_req;

  assign div_en      = (state_reg == ST_SLOW);
  assign ctrl_wr     = wr_in && addr_in == ADDR_CTRL;
  assign pm_req      = rbpc_pm_t'(wdata_in[CTRL_MODE_LSB +: 2]);
  assign wdt_expire  = wdt_en_reg && wdt_cnt_reg == 16'h0000
                       && state_reg != ST_RESET && state_reg != ST_PDOWN;
  // watchdog resets keep the previous boot selection
  assign boot_sample = state_reg == ST_RESET && !hw_level
                       && stretch_reg == 4'h0 && !cause_reg.wdt;

  always_comb begin
    state_next   = state_reg;
    stretch_next = stretch_reg;
    cause_next   = cause_reg;
    ram_next     = ram_reg;
    boot_next    = boot_reg;
    div_next     = div_reg;
    if (wr_in && addr_in == ADDR_STATUS) begin
      cause_next = cause_reg & ~rbpc_cause_t'(wdata_in[STAT_CAUSE_LSB +: 4]);
    end
    // set below overrides the clear above
    if (hw_level) begin
      state_next   = ST_RESET;
      stretch_next = 4'(RST_STRETCH_CYC);
      if (state_reg != ST_RESET) begin
        cause_next      = '0;
        cause_next.hw   = 1'b1;
        cause_next.wake = (state_reg == ST_PDOWN);
        ram_next        = 1'b1;
      end
    end else if (wdt_expire) begin
      state_next   = ST_RESET;
      stretch_next = 4'(RST_STRETCH_CYC);
      cause_next   = '0;
      cause_next.wdt = 1'b1;
      ram_next     = 1'b1;
    end else begin
      unique case (state_reg)
        ST_RESET: begin
          if (stretch_reg != 4'h0) begin
            stretch_next = stretch_reg - 4'h1;
          end else begin
            state_next = ST_RUN;
            div_next   = DIV_RST;
            if (boot_sample) begin
              boot_next = decode_boot(strap_in, flash_protected_in);
            end
          end
        end
        ST_RUN, ST_SLOW: begin
          if (ctrl_wr) begin
            div_next = wdata_in[CTRL_DIV_LSB +: 3];
            unique case (pm_req)
              PM_RUN:   state_next = ST_RUN;
              PM_IDLE:  state_next = ST_IDLE;
              PM_SLOW:  state_next = ST_SLOW;
              PM_PDOWN: state_next = ST_PDOWN;
            endcase
          end
        end
        ST_IDLE: begin
          if (wake_event_in) begin
            state_next = ST_RUN;
          end
        end
        // only a hardware reset leaves power-down
        ST_PDOWN: state_next = ST_PDOWN;
        default: state_next = ST_RESET;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // clock gating and reset outputs

  always_comb begin
    clk_next    = '{osc_en: 1'b1, pll_en: 1'b1, evr_on: 1'b1,
                    cpu_clk_en: 1'b1, periph_clk_en: 1'b1};
    sysrst_next = 1'b0;
    unique case (state_reg)
      ST_RESET: begin
        sysrst_next = 1'b1;
        clk_next.evr_on = 1'b1;
      end
      ST_RUN: ;
      ST_IDLE: clk_next.cpu_clk_en = 1'b0;
      ST_SLOW: begin
        clk_next.cpu_clk_en    = div_tick;
        clk_next.periph_clk_en = div_tick;
      end
      ST_PDOWN: begin
        clk_next = '0;
      end
      default: sysrst_next = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // watchdog and register port

  always_comb begin
    wdt_en_next  = wdt_en_reg;
    reload_next  = reload_reg;
    wdt_cnt_next = wdt_cnt_reg;
    if (state_reg == ST_RESET) begin
      wdt_en_next  = 1'b0;
      wdt_cnt_next = {reload_reg, WDT_LOW_FILL};
    end else if (wr_in && addr_in == ADDR_WDT_CTRL) begin
      wdt_en_next = wdata_in[WDT_EN_BIT];
      if (wdata_in[WDT_SERV_BIT] || !wdt_en_reg) begin
        wdt_cnt_next = {reload_reg, WDT_LOW_FILL};
      end
    end else if (wr_in && addr_in == ADDR_WDT_RELOAD) begin
      reload_next = wdata_in;
    end else if (wdt_en_reg && state_reg != ST_PDOWN
                 && wdt_cnt_reg != 16'h0000) begin
      wdt_cnt_next = wdt_cnt_reg - 16'h0001;
    end
    rdata_next = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        ADDR_CTRL: begin
          rdata_next[CTRL_DIV_LSB +: 3] = div_reg;
          rdata_next[CTRL_MODE_LSB +: 2] =
            (state_reg == ST_IDLE)  ? PM_IDLE  :
            (state_reg == ST_SLOW)  ? PM_SLOW  :
            (state_reg == ST_PDOWN) ? PM_PDOWN : PM_RUN;
        end
        ADDR_STATUS: begin
          rdata_next[STAT_CAUSE_LSB +: 4] = cause_reg;
          rdata_next[STAT_BOOT_LSB +: 2]  = boot_reg.mode;
          rdata_next[STAT_RAM_BIT]        = ram_reg;
          rdata_next[STAT_JTAG_BIT]       = boot_reg.jtag_hot_attach;
        end
        ADDR_WDT_CTRL:   rdata_next[WDT_EN_BIT] = wdt_en_reg;
        ADDR_WDT_RELOAD: rdata_next = reload_reg;
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg   <= ST_RESET;
      stretch_reg <= 4'(RST_STRETCH_CYC);
      cause_reg   <= '{wake: 1'b0, wdt: 1'b0, hw: 1'b0, por: 1'b1};
      ram_reg     <= 1'b0;
      boot_reg    <= '{mode: BOOT_USER, jtag_hot_attach: 1'b0,
                       pc_start: PC_START};
      div_reg     <= DIV_RST;
      clk_reg     <= '{osc_en: 1'b1, pll_en: 1'b1, evr_on: 1'b1,
                       cpu_clk_en: 1'b0, periph_clk_en: 1'b0};
      sysrst_reg  <= 1'b1;
      wdt_en_reg  <= 1'b0;
      reload_reg  <= WDT_RELOAD_RST;
      wdt_cnt_reg <= 16'hffff;
      rdata_reg   <= 8'h00;
    end else begin
      state_reg   <= state_next;
      stretch_reg <= stretch_next;
      cause_reg   <= cause_next;
      ram_reg     <= ram_next;
      boot_reg    <= boot_next;
      div_reg     <= div_next;
      clk_reg     <= clk_next;
      sysrst_reg  <= sysrst_next;
      wdt_en_reg  <= wdt_en_next;
      reload_reg  <= reload_next;
      wdt_cnt_reg <= wdt_cnt_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign rdata_out     = rdata_reg;
  assign sys_reset_out = sysrst_reg;
  assign clk_ctl_out   = clk_reg;
  assign boot_out      = boot_reg;
  assign cause_out     = cause_reg;
  assign ram_valid_out = ram_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks

  a_hw_reset_entry: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    hw_level |=> state_reg == ST_RESET ##1 sys_reset_out)
    else $error("hardware reset not taken");

  a_wdt_reset_entry: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    wdt_expire && !hw_level |=> state_reg == ST_RESET && cause_reg.wdt)
    else $error("watchdog expiry did not reset");

  a_wake_cause: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    state_reg == ST_PDOWN && hw_level |=> cause_reg.wake && ram_valid_out)
    else $error("wake-up reset not flagged");

  a_evr_back_on: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    state_reg == ST_PDOWN && hw_level |=> ##1 clk_ctl_out.evr_on)
    else $error("regulator not restored on wake-up");

  a_boot_user: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    boot_sample && strap_in.boot_mode_pin && !strap_in.tms
    |=> boot_out.mode == BOOT_USER && boot_out.pc_start == PC_START)
    else $error("user boot not selected");

  a_boot_loader: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    boot_sample && !strap_in.boot_mode_pin && !strap_in.tms
    |=> boot_out.mode == BOOT_LOADER)
    else $error("loader boot not selected");

  a_debug_locked: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    boot_sample && strap_in == 3'b010
    |=> boot_out.mode == (flash_protected_in ? BOOT_USER : BOOT_DEBUG))
    else $error("debug boot gating wrong");

  a_jtag_user: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    boot_sample && strap_in == 3'b110
    |=> boot_out.mode == BOOT_JTAG_USER && boot_out.jtag_hot_attach)
    else $error("jtag user boot not selected");

  a_undef_default: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    boot_sample && strap_in.tms && strap_in.port_zero_bit_zero
    |=> boot_out.mode == BOOT_USER && !boot_out.jtag_hot_attach)
    else $error("undefined straps not mapped to user");

  a_idle_cpu_only: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    state_reg == ST_IDLE && $past(state_reg) == ST_IDLE
    |-> !clk_ctl_out.cpu_clk_en && clk_ctl_out.periph_clk_en
        && clk_ctl_out.osc_en && clk_ctl_out.pll_en)
    else $error("idle gating wrong");

  a_slow_common: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $past(state_reg) == ST_SLOW
    |-> clk_ctl_out.cpu_clk_en == clk_ctl_out.periph_clk_en)
    else $error("slow-down enables differ");

  a_pdown_osc_off: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $past(state_reg) == ST_PDOWN
    |-> !clk_ctl_out.osc_en && !clk_ctl_out.pll_en)
    else $error("oscillator left on in power-down");

endmodule

// >>> rbpc_ext_model.sv
// rbpc_ext_model: external reset source and boot strap pins
module rbpc_ext_model (
  input  logic                  clk_sys_in,
  input  logic                  pulse_in,
  input  logic [3:0]            len_in,
  input  rbpc_pkg::rbpc_strap_t strap_val_in,
  output logic                  ext_reset_n_out,
  output rbpc_pkg::rbpc_strap_t strap_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import rbpc_pkg::*;

  logic [3:0] cnt_reg = 4'h0;

  always @(posedge clk_sys_in) begin
    if (pulse_in) begin
      cnt_reg <= len_in;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // pin low for len_in cycles; a length of 1 is a deliberate glitch
  assign ext_reset_n_out = (cnt_reg == 4'h0);
  // straps are levels held across the whole reset
  assign strap_out = strap_val_in;
endmodule

// >>> rbpc_top_bench.sv
// rbpc_top_bench: self-checking bench for the reset/boot/power block
module rbpc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rbpc_pkg::*;

  logic            clk_sys_in = 1'b0;
  logic            rst_in = 1'b1;
  logic            flash_protected_in = 1'b0;
  logic            wake_event_in = 1'b0;
  logic            wr_in = 1'b0;
  logic            rd_in = 1'b0;
  logic            pulse = 1'b0;
  logic [3:0]      addr_in = 4'h0;
  logic [3:0]      len = 4'h0;
  logic [7:0]      wdata_in = 8'h00;
  logic [7:0]      rdata_out;
  logic [7:0]      v;
  logic [2:0]      strap_val = 3'h4;
  rbpc_strap_t     strap_in;
  logic            ext_reset_n_in;
  logic            sys_reset_out;
  logic            ram_valid_out;
  rbpc_clk_t       clk_ctl_out;
  rbpc_boot_info_t boot_out;
  rbpc_boot_info_t b;
  rbpc_cause_t     cause_out;
  int              err_count = 0;
  int              checks = 0;
  int              cyc = 0;
  logic [31:0]     seed = 32'd53956;

  always #25 clk_sys_in = ~clk_sys_in;

  rbpc_ext_model PARTNER (.clk_sys_in(clk_sys_in), .pulse_in(pulse),
    .len_in(len), .strap_val_in(rbpc_strap_t'(strap_val)),
    .ext_reset_n_out(ext_reset_n_in), .strap_out(strap_in));

  rbpc_top DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .ext_reset_n_in(ext_reset_n_in), .strap_in(strap_in),
    .flash_protected_in(flash_protected_in), .wake_event_in(wake_event_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sys_reset_out(sys_reset_out),
    .clk_ctl_out(clk_ctl_out), .boot_out(boot_out), .cause_out(cause_out),
    .ram_valid_out(ram_valid_out));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // unlisted patterns and a protected debug request fall back to user mode
  function automatic rbpc_boot_info_t exp_boot(logic [2:0] s, logic p);
    rbpc_boot_info_t e;
    e = '{mode: BOOT_USER, jtag_hot_attach: 1'b0, pc_start: PC_START};
    if (!s[1]) begin
      e.mode = s[2] ? BOOT_USER : BOOT_LOADER;
    end else if (!s[0] && s[2]) begin
      e.mode = BOOT_JTAG_USER;
      e.jtag_hot_attach = 1'b1;
    end else if (!s[0] && !p) begin
      e.mode = BOOT_DEBUG;
    end
    return e;
  endfunction

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_val(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_boot(input rbpc_boot_info_t e, input rbpc_boot_info_t g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value boot exp %h got %h", e, g);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // bounded wait for an internal reset to start and then finish
  task automatic wait_boot();
    int n;
    n = 0;
    while (sys_reset_out !== 1'b1 && n < 500) begin
      tick();
      n++;
    end
    chk_val("sys_reset_on", 8'h01, 8'(sys_reset_out));
    n = 0;
    while (sys_reset_out !== 1'b0 && n < 60) begin
      tick();
      n++;
    end
    chk_val("sys_reset", 8'h00, 8'(sys_reset_out));
  endtask

  task automatic hw_reset(input logic [3:0] l);
    @(posedge clk_sys_in);
    pulse <= 1'b1;
    len <= l;
    @(posedge clk_sys_in);
    pulse <= 1'b0;
    wait_boot();
  endtask

  task automatic pulse_wake();
    @(posedge clk_sys_in);
    wake_event_in <= 1'b1;
    @(posedge clk_sys_in);
    wake_event_in <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // ceiling well above the roughly 1100 cycles the sequence needs
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    int n;
    int m;
    logic [2:0] f;
    logic [7:0] d;
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    wait_boot();
    chk_val("cause", 8'h01, 8'(cause_out));
    chk_val("ram", 8'h00, 8'(ram_valid_out));
    chk_boot(exp_boot(3'h4, 1'b0), boot_out);
    chk_val("clk_ctl", 8'h1f, 8'(clk_ctl_out));
    // every strap pattern with and without protection, then random ones
    for (int i = 0; i < 20; i++) begin
      d = 8'(xs());
      @(posedge clk_sys_in);
      strap_val <= (i < 16) ? 3'(i >> 1) : d[2:0];
      flash_protected_in <= (i < 16) ? i[0] : d[3];
      hw_reset(4'h4 + 4'(d[5:4]));
      b = exp_boot(strap_val, flash_protected_in);
      chk_boot(b, boot_out);
      rd(ADDR_STATUS, v);
      chk_val("status", {b.jtag_hot_attach, 1'b1, b.mode, 4'h2}, v);
    end
    wr(ADDR_STATUS, 8'h0f);
    rd(ADDR_STATUS, v);
    chk_val("cause_clr", 8'h00, {4'h0, v[3:0]});
    d = 8'(xs());
    wr(4'hf, d);
    rd(4'hf, v);
    chk_val("unmapped", 8'h00, v);
    wr(ADDR_WDT_RELOAD, d);
    rd(ADDR_WDT_RELOAD, v);
    chk_val("reload", d, v);
    // single-cycle glitch on the pin must not reset
    @(posedge clk_sys_in);
    pulse <= 1'b1;
    len <= 4'h1;
    @(posedge clk_sys_in);
    pulse <= 1'b0;
    m = 0;
    repeat (12) begin
      tick();
      m += sys_reset_out;
    end
    chk_val("glitch", 8'h00, 8'(m));
    wr(ADDR_CTRL, 8'h01);
    repeat (3) tick();
    chk_val("idle_clk", 8'h1d, 8'(clk_ctl_out));
    pulse_wake();
    repeat (3) tick();
    chk_val("run_clk", 8'h1f, 8'(clk_ctl_out));
    f = 3'(xs());
    wr(ADDR_CTRL, {3'h0, f, 2'h2});
    rd(ADDR_CTRL, v);
    chk_val("ctrl", {3'h0, f, 2'h2}, v & 8'h1f);
    n = 0;
    m = 0;
    repeat (8 * (int'(f) + 1)) begin
      tick();
      n += clk_ctl_out.cpu_clk_en;
      m += (clk_ctl_out.cpu_clk_en !== clk_ctl_out.periph_clk_en);
    end
    chk_val("slow_pulses", 8'h08, 8'(n));
    chk_val("slow_common", 8'h00, 8'(m));
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h03);
    repeat (3) tick();
    chk_val("osc_pll", 8'h00, 8'(clk_ctl_out[4:3]));
    hw_reset(4'h5);
    chk_val("wake_cause", 8'h0a, 8'(cause_out));
    chk_val("wake_ram", 8'h01, 8'(ram_valid_out));
    chk_val("evr_on", 8'h01, 8'(clk_ctl_out.evr_on));
    // watchdog reset keeps the boot choice although the straps moved
    b = boot_out;
    @(posedge clk_sys_in);
    strap_val <= ~strap_val;
    wr(ADDR_WDT_RELOAD, 8'h00);
    wr(ADDR_WDT_CTRL, 8'h01);
    rd(ADDR_WDT_CTRL, v);
    chk_val("wdt_en", 8'h01, v);
    // a service well before the 255-cycle expiry must postpone the reset
    repeat (200) tick();
    wr(ADDR_WDT_CTRL, 8'h03);
    m = 0;
    repeat (150) begin
      tick();
      m += sys_reset_out;
    end
    chk_val("wdt_serviced", 8'h00, 8'(m));
    wait_boot();
    chk_val("wdt_cause", 8'h04, 8'(cause_out));
    chk_val("wdt_ram", 8'h01, 8'(ram_valid_out));
    chk_boot(b, boot_out);
    report_and_stop();
  end
endmodule
